/* File: ips_pfet_model.sv */
/*
 * ips_pfet_model: the two external pass pFETs with gate pull-ups.
 * Assumes open-drain gate pins as data plus output enable.
 */
`timescale 1ns/1ns
module ips_pfet_model (
	input wire logic main_gate_in,
	input wire logic main_oe_in,
	input wire logic batt_gate_in,
	input wire logic batt_oe_in,
	output logic main_on_out,
	output logic batt_on_out
);
	// released pin floats up through the resistor, so the pFET is off
	assign main_on_out = main_oe_in ? ~main_gate_in : 1'b0;
	assign batt_on_out = batt_oe_in ? ~batt_gate_in : 1'b0;
endmodule

/* File: ips_pkg.sv */
/*
 * ips_pkg: shared constants and carrier types for the input protection
 * switchover controller. Assumes a 10 MHz system clock.
 */
package ips_pkg;
	// system clock
	localparam int CLK_HZ = 10000000;
	// debounce and blanking, nominal figures in milliseconds
	localparam int DEBOUNCE_MS = 25;
	localparam int BLANKING_MS = 25;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int BLANKING_CYC = BLANKING_MS * (CLK_HZ / 1000);
	localparam int TMR_W = 24;
	// synchroniser depth
	localparam int SYNC_STAGES = 2;
	localparam int SENSE_W = 5;

	// digitised comparator results and host select
	typedef struct packed {
		logic upper_threshold_sense;  // input above upper lockout
		logic lower_threshold_sense;  // input below lower lockout
		logic internal_uv;            // input below internal trip
		logic adapter_unplugged;      // input below power-on trip
		logic battery_select;
	} ips_sense_s;

	// open-drain gate pin pair
	typedef struct packed {
		logic main_oe;
		logic batt_oe;
	} ips_gate_s;

	typedef enum logic [2:0] {
		ST_UNPLUGGED = 3'h0,
		ST_DEBOUNCE = 3'h1,
		ST_ON = 3'h2,
		ST_BLANK = 3'h3,
		ST_LATCHED = 3'h4
	} ips_state_e;
endpackage

/* File: ips_switchover.sv */
/*
 * ips_switchover: protection state machine driving the main pass switch
 * and battery pass switch gates as open-drain enables.
 * Assumes digitised comparator levels and a power-on reset from outside.
 */
// Behaviour
// - main switch closes after in-window debounce
// - above upper threshold opens switch immediately
// - undervoltage while on starts blanking, switch held
// - undervoltage cleared in blanking keeps switch on
// - persistent undervoltage latches off until unplug
// - main gate driven low only without overvoltage or internal undervoltage
// - battery select high: main off, battery on
// - battery select low: battery gate released
// - battery select steers main only while on or blanking
// - overvoltage has no blanking; debounce afterwards
// - internal undervoltage while on or blanking opens and latches immediately; in debounce it only restarts the count
// - unplug then replug restarts debounce
`timescale 1ns/1ns
module ips_switchover #(
	parameter int DEBOUNCE_CYCLES = ips_pkg::DEBOUNCE_CYC,
	parameter int BLANKING_CYCLES = ips_pkg::BLANKING_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire ips_pkg::ips_sense_s sense_in,
	output logic main_switch_gate_out,
	output logic main_switch_gate_oe_out,
	output logic battery_switch_gate_out,
	output logic battery_switch_gate_oe_out
);
	ips_pkg::ips_sense_s sense_sync;
	ips_pkg::ips_state_e state_reg;
	ips_pkg::ips_gate_s gate_reg;
	logic [ips_pkg::TMR_W-1:0] timer_reg;
	logic in_window;
	logic ov;
	logic uv;
	logic iuv;
	logic unplug;
	logic sel;

	// all sense levels cross into the clock domain first
	ips_sync #(
		.WIDTH(ips_pkg::SENSE_W),
		.STAGES(ips_pkg::SYNC_STAGES)
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.d_in(sense_in),
		.q_out(sense_sync)
	);

	assign ov = sense_sync.upper_threshold_sense;
	assign uv = sense_sync.lower_threshold_sense;
	assign iuv = sense_sync.internal_uv;
	assign unplug = sense_sync.adapter_unplugged;
	assign sel = sense_sync.battery_select;
	assign in_window = !ov && !uv && !iuv && !unplug;

	// protection sequencer; reset clears latch and timers
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state_reg <= ips_pkg::ST_UNPLUGGED;
			timer_reg <= '0;
		end else begin
			case (state_reg)
				ips_pkg::ST_UNPLUGGED: begin
					timer_reg <= '0;
					// replug restarts the debounce sequence
					if (!unplug) begin
						state_reg <= ips_pkg::ST_DEBOUNCE;
					end
				end
				ips_pkg::ST_DEBOUNCE: begin
					if (unplug) begin
						state_reg <= ips_pkg::ST_UNPLUGGED;
						timer_reg <= '0;
					end else if (!in_window) begin
						timer_reg <= '0; // any excursion restarts debounce
					end else if (timer_reg == ips_pkg::TMR_W'(DEBOUNCE_CYCLES - 1)) begin
						state_reg <= ips_pkg::ST_ON;
						timer_reg <= '0;
					end else begin
						timer_reg <= timer_reg + 1'b1;
					end
				end
				ips_pkg::ST_ON: begin
					timer_reg <= '0;
					if (unplug) begin
						state_reg <= ips_pkg::ST_UNPLUGGED;
					end else if (iuv) begin
						state_reg <= ips_pkg::ST_LATCHED; // no blanking below internal trip
					end else if (ov) begin
						state_reg <= ips_pkg::ST_DEBOUNCE; // immediate off
					end else if (uv) begin
						state_reg <= ips_pkg::ST_BLANK;
					end
				end
				ips_pkg::ST_BLANK: begin
					if (unplug) begin
						state_reg <= ips_pkg::ST_UNPLUGGED;
						timer_reg <= '0;
					end else if (iuv) begin
						state_reg <= ips_pkg::ST_LATCHED;
						timer_reg <= '0;
					end else if (ov) begin
						state_reg <= ips_pkg::ST_DEBOUNCE;
						timer_reg <= '0;
					end else if (timer_reg == ips_pkg::TMR_W'(BLANKING_CYCLES - 1)) begin
						// judged only at the end of the interval
						state_reg <= uv ? ips_pkg::ST_LATCHED : ips_pkg::ST_ON;
						timer_reg <= '0;
					end else begin
						timer_reg <= timer_reg + 1'b1;
					end
				end
				ips_pkg::ST_LATCHED: begin
					timer_reg <= '0;
					// besides reset, only adapter removal clears the latch
					if (unplug) begin
						state_reg <= ips_pkg::ST_UNPLUGGED;
					end
				end
				default: begin
					state_reg <= ips_pkg::ST_UNPLUGGED;
					timer_reg <= '0;
				end
			endcase
		end
	end

	// gate drive; main pulled low only when on or blanking, free of overvoltage and internal uv, and not selected
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			gate_reg <= '0;
		end else begin
			gate_reg.main_oe <= (state_reg == ips_pkg::ST_ON || state_reg == ips_pkg::ST_BLANK)
				&& !ov && !iuv && !sel;
			gate_reg.batt_oe <= sel;
		end
	end

	// open drain: data is always low, enable does the work
	assign main_switch_gate_out = 1'b0;
	assign battery_switch_gate_out = 1'b0;
	assign main_switch_gate_oe_out = gate_reg.main_oe;
	assign battery_switch_gate_oe_out = gate_reg.batt_oe;

	property p_ov_opens;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		ov |=> !main_switch_gate_oe_out;
	endproperty
	a_ov_opens: assert property (p_ov_opens) else $error("main gate held during overvoltage");

	property p_sel_batt;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		sel |=> battery_switch_gate_oe_out && !main_switch_gate_oe_out;
	endproperty
	a_sel_batt: assert property (p_sel_batt) else $error("select did not swap gates");

	property p_unsel_batt;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		!sel |=> !battery_switch_gate_oe_out;
	endproperty
	a_unsel_batt: assert property (p_unsel_batt) else $error("battery gate driven without select");

	property p_debounce_full;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		$rose(state_reg == ips_pkg::ST_ON) |-> $past(timer_reg) == ips_pkg::TMR_W'(DEBOUNCE_CYCLES - 1)
			|| $past(state_reg) == ips_pkg::ST_BLANK;
	endproperty
	a_debounce_full: assert property (p_debounce_full) else $error("switch closed before debounce");

	property p_blank_holds;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(state_reg == ips_pkg::ST_ON && uv && !ov && !iuv && !unplug) |=> state_reg == ips_pkg::ST_BLANK;
	endproperty
	a_blank_holds: assert property (p_blank_holds) else $error("blanking not started");

	property p_latch_stays;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(state_reg == ips_pkg::ST_LATCHED && !unplug) |=> state_reg == ips_pkg::ST_LATCHED;
	endproperty
	a_latch_stays: assert property (p_latch_stays) else $error("latch cleared without unplug");

	property p_iuv_latch;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(iuv && !unplug && state_reg == ips_pkg::ST_ON) |=> state_reg == ips_pkg::ST_LATCHED ##1 !main_switch_gate_oe_out;
	endproperty
	a_iuv_latch: assert property (p_iuv_latch) else $error("internal undervoltage not latched");

	property p_fault_release;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(state_reg != ips_pkg::ST_ON && state_reg != ips_pkg::ST_BLANK) |=> !main_switch_gate_oe_out;
	endproperty
	a_fault_release: assert property (p_fault_release) else $error("main gate driven while off");

	// blanking verdict, judged once when the timer runs out
	sequence s_blank_expiry;
		state_reg == ips_pkg::ST_BLANK && timer_reg == ips_pkg::TMR_W'(BLANKING_CYCLES - 1)
			&& !unplug && !iuv && !ov;
	endsequence

	// dip still present at expiry: latch, then release the gate
	property p_uv_latch;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_blank_expiry ##0 uv |=> state_reg == ips_pkg::ST_LATCHED
			##1 !main_switch_gate_oe_out;
	endproperty
	a_uv_latch: assert property (p_uv_latch) else $error("undervoltage not latched");

	// dip gone by expiry: the pending fault is dropped
	property p_uv_forgive;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_blank_expiry ##0 !uv |=> state_reg == ips_pkg::ST_ON;
	endproperty
	a_uv_forgive: assert property (p_uv_forgive) else $error("cleared dip not forgiven");

	// replug seen from the unplugged state restarts a fresh count
	sequence s_replug;
		state_reg == ips_pkg::ST_UNPLUGGED && !unplug;
	endsequence

	property p_replug;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		s_replug |=> state_reg == ips_pkg::ST_DEBOUNCE && timer_reg == '0;
	endproperty
	a_replug: assert property (p_replug) else $error("replug did not restart debounce");

	// reset must leave both gates released and nothing pending
	property p_reset_clear;
		@(posedge sys_clk_in)
		!rst_b_in |=> state_reg == ips_pkg::ST_UNPLUGGED && timer_reg == '0
			&& !main_switch_gate_oe_out && !battery_switch_gate_oe_out;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind");
endmodule

/* File: ips_sync.sv */
/*
 * ips_sync: multi-stage synchroniser for a bus of levels.
 * Assumes inputs are static relative to the clock for several cycles.
 */
`timescale 1ns/1ns
module ips_sync #(
	parameter int WIDTH = 5,
	parameter int STAGES = 2
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] stage_reg [STAGES];

	// first stage read only by the next stage
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_reg[i] <= '0;
			end
		end else begin
			stage_reg[0] <= d_in;
			for (int i = 1; i < STAGES; i++) begin
				stage_reg[i] <= stage_reg[i-1];
			end
		end
	end

	assign q_out = stage_reg[STAGES-1];
endmodule

/* File: testbench.sv */
/*
 * testbench: self-checking bench for ips_switchover with short timers.
 * Assumes the pFET model in ips_pfet_model and a 10 MHz clock.
 */
`timescale 1ns/1ns
module testbench;
	localparam int DEB = 20;
	localparam int BLK = 30;
	logic sys_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	ips_pkg::ips_sense_s sense = 5'h02;
	logic mg, moe, bg, boe, main_on, batt_on;
	logic [31:0] r;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	integer seed = 32'h26BE8FA3;

	// 100 ns period
	always #50 sys_clk_in = ~sys_clk_in;

	ips_switchover #(.DEBOUNCE_CYCLES(DEB), .BLANKING_CYCLES(BLK)) dut (
		.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .sense_in(sense),
		.main_switch_gate_out(mg), .main_switch_gate_oe_out(moe),
		.battery_switch_gate_out(bg), .battery_switch_gate_oe_out(boe));

	ips_pfet_model fets (.main_gate_in(mg), .main_oe_in(moe), .batt_gate_in(bg),
		.batt_oe_in(boe), .main_on_out(main_on), .batt_on_out(batt_on));

	// expected switch pair: main passes only when armed and unselected
	function automatic logic [1:0] gates(input logic on, input logic sel);
		return {on & ~sel, sel};
	endfunction

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask

	// bits: upper, lower, internal uv, unplugged, select
	task automatic drive(input logic [4:0] v);
		@(posedge sys_clk_in);
		sense <= v;
	endtask

	// sample away from the edge so registered outputs have landed
	task automatic check(input logic on, input logic sel);
		logic [1:0] e;
		#10;
		e = gates(on, sel);
		checked++;
		if ({main_on, batt_on} !== e) begin
			num_errors++;
			$display("unexpected at %0t: exp %h got %h", $time, e, {main_on, batt_on});
		end
	endtask

	task automatic conclude;
		if (num_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// hang guard, well above the few hundred cycles needed
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end

	initial begin
		wait_cyc(3);
		rst_b_in <= 1'b1;
		check(0, 0);
		drive(5'h00);
		wait_cyc(DEB - 2);
		check(0, 0);
		wait_cyc(10);
		check(1, 0);
		drive(5'h01);
		wait_cyc(5);
		check(0, 1);
		drive(5'h00);
		wait_cyc(5);
		check(1, 0);
		// host toggles select at random while armed
		repeat (20) begin
			r = $random(seed);
			drive({4'h0, r[0]});
			wait_cyc(5);
			check(1, r[0]);
		end
		drive(5'h10);
		wait_cyc(5);
		check(0, 0);
		drive(5'h11);
		wait_cyc(5);
		check(0, 1);
		drive(5'h00);
		wait_cyc(DEB - 2);
		check(0, 0);
		wait_cyc(10);
		check(1, 0);
		// short dip must be forgiven
		drive(5'h08);
		wait_cyc(10);
		check(1, 0);
		drive(5'h00);
		wait_cyc(BLK + 10);
		check(1, 0);
		drive(5'h08);
		wait_cyc(BLK - 5);
		check(1, 0);
		wait_cyc(15);
		check(0, 0);
		drive(5'h00);
		wait_cyc(DEB + 10);
		check(0, 0);
		drive(5'h02);
		wait_cyc(5);
		drive(5'h00);
		wait_cyc(DEB - 2);
		check(0, 0);
		wait_cyc(10);
		check(1, 0);
		drive(5'h04);
		wait_cyc(5);
		check(0, 0);
		drive(5'h00);
		wait_cyc(DEB + 10);
		check(0, 0);
		// second reset clears the latch
		@(posedge sys_clk_in);
		rst_b_in <= 1'b0;
		wait_cyc(3);
		check(0, 0);
		// release on an edge, like every other input change
		@(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		wait_cyc(DEB + 10);
		check(1, 0);
		conclude();
	end
endmodule
